// *** common/rsa_pkg.sv ***
// package: register map, field positions and reset values of the range/alarm register bank
package rsa_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int RESULT_W = 18;
	localparam int LIMIT_W = 16;
	localparam int HYST_W = 8;
	localparam int NUM_TRIP = 4;

	// register offsets
	localparam logic [ADDR_W-1:0] RANGE_OFS = 8'h14;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h20;
	localparam logic [ADDR_W-1:0] UPPER_OFS = 8'h24;
	localparam logic [ADDR_W-1:0] LOWER_OFS = 8'h28;
	localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h30;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h34;

	// input_span_and_reference_control fields
	localparam int REF_OFF_BIT = 6;
	localparam int SPAN_LSB = 0;
	localparam int SPAN_W = 4;
	localparam logic REF_OFF_RST = 1'h0;
	localparam logic [SPAN_W-1:0] SPAN_RST = 4'h0;
	localparam logic [SPAN_W-1:0] SPAN_BIP_LAST = 4'h4;
	localparam logic [SPAN_W-1:0] SPAN_UNI_FIRST = 4'h8;
	localparam logic [SPAN_W-1:0] SPAN_UNI_LAST = 4'hB;

	// alarm_flag_status fields
	localparam int SUP_LOW_ACT_BIT = 15;
	localparam int SUP_HIGH_ACT_BIT = 14;
	localparam int IN_LOW_ACT_BIT = 11;
	localparam int IN_HIGH_ACT_BIT = 10;
	localparam int TRIP_LSB = 4;
	localparam int SUMMARY_BIT = 0;
	// order of latched flags inside the 4-bit trip vector (bit 7..4 of status)
	localparam int TRIP_SUP_LOW = 3;
	localparam int TRIP_SUP_HIGH = 2;
	localparam int TRIP_IN_LOW = 1;
	localparam int TRIP_IN_HIGH = 0;

	// threshold registers
	localparam int HYST_LSB = 24;
	localparam int LIMIT_LSB = 0;
	localparam logic [LIMIT_W-1:0] UPPER_RST = 16'hFFFF;
	localparam logic [LIMIT_W-1:0] LOWER_RST = 16'h0000;
	localparam logic [HYST_W-1:0] HYST_RST = 8'h00;
	localparam logic [NUM_TRIP-1:0] MASK_RST = 4'h0;

	// a 16-bit limit compares as limit appended with two zero bits
	function automatic logic [RESULT_W-1:0] limit_to_result(input logic [LIMIT_W-1:0] lim);
		limit_to_result = {lim, 2'h0};
	endfunction

	function automatic logic span_code_defined(input logic [SPAN_W-1:0] code);
		span_code_defined = (code <= SPAN_BIP_LAST)
			|| ((code >= SPAN_UNI_FIRST) && (code <= SPAN_UNI_LAST));
	endfunction
endpackage

// *** rtl/rsa_limit_cmp.sv ***
// one input-limit comparator with hysteresis, updated once per conversion
`timescale 1ns/1ps
module rsa_limit_cmp #(
	parameter int RESULT_W = 18,
	parameter bit UPPER = 1'b1
) (
	// clock and reset
	input  wire logic                clk_in,
	input  wire logic                arst_n_in,
	// conversion result
	input  wire logic                sample_valid_in,
	input  wire logic [RESULT_W-1:0] sample_in,
	// limit and hysteresis, already in result units
	input  wire logic [RESULT_W-1:0] limit_in,
	input  wire logic [RESULT_W-1:0] hyst_in,
	// active alarm
	output logic                     active_out
);
	logic                next_active;
	logic [RESULT_W:0]   release_pt;

	always_comb begin
		next_active = active_out;
		// extra bit keeps limit +/- hysteresis from wrapping
		if (UPPER) begin
			release_pt = {1'b0, limit_in} - {1'b0, hyst_in};
		end else begin
			release_pt = {1'b0, limit_in} + {1'b0, hyst_in};
		end
		if (sample_valid_in) begin
			if (UPPER) begin
				if (sample_in > limit_in) begin
					next_active = 1'b1;
				end else if (release_pt[RESULT_W] || ({1'b0, sample_in} < release_pt)) begin
					next_active = 1'b0;
				end
			end else begin
				if (sample_in < limit_in) begin
					next_active = 1'b1;
				end else if ({1'b0, sample_in} > release_pt) begin
					next_active = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			active_out <= 1'b0;
		end else begin
			active_out <= next_active;
		end
	end
endmodule

// *** rtl/rsa_range_alarm.sv ***
// range select, alarm status and alarm interrupt register bank
//
// Function
// - bits 31..16 of range and alarm status registers read zero.
// - range register bits 15..8, 7 and 5..4 read zero.
// - range bit 6 resets 0; 1 turns the on-chip reference off.
// - range code bits 3..0 reset 0; codes 0..4 are bipolar spans.
// - codes 8..11 are unipolar spans; no other code is defined.
// - status bit 15 shows a live low analog supply alarm.
// - status bit 14 shows a live high analog supply alarm.
// - status bits 11 and 10 show the live input alarms.
// - status bits 7 and 6 latch low and high supply alarms.
// - status bits 5 and 4 latch the input alarms.
// - status bits 13..12, 9..8 and 3..1 read zero.
// - status bit 0 is the OR of the four latched alarms.
// - the alarm status register ignores every write.
// - upper input alarm compares the result with the upper limit times four.
// - lower input alarm compares the result with the lower limit times four.
// - hysteresis comes from the upper six bits of its field.
`timescale 1ns/1ps
module rsa_range_alarm #(
	parameter int RESULT_W = rsa_pkg::RESULT_W
) (
	// clock and reset
	input  wire logic                        clk_in,
	input  wire logic                        arst_n_in,
	// register port
	input  wire logic [rsa_pkg::ADDR_W-1:0]  reg_addr_in,
	input  wire logic [rsa_pkg::DATA_W-1:0]  reg_wdata_in,
	input  wire logic                        reg_wr_in,
	input  wire logic                        reg_rd_in,
	output logic      [rsa_pkg::DATA_W-1:0]  reg_rdata_out,
	// conversion result and supply monitors
	input  wire logic                        sample_valid_in,
	input  wire logic [RESULT_W-1:0]         sample_in,
	input  wire logic                        analog_supply_low_in,
	input  wire logic                        analog_supply_high_in,
	// controls to the analog side
	output logic      [rsa_pkg::SPAN_W-1:0]  span_code_out,
	output logic                             onchip_reference_off_out,
	// interrupt
	output logic                             irq_out
);
	logic [rsa_pkg::LIMIT_W-1:0]  input_upper_limit;
	logic [rsa_pkg::LIMIT_W-1:0]  input_lower_limit;
	logic [rsa_pkg::HYST_W-1:0]   input_limit_hysteresis;
	logic [rsa_pkg::NUM_TRIP-1:0] irq_mask;
	logic                         supply_low_active;
	logic                         supply_high_active;
	logic [rsa_pkg::LIMIT_W-1:0]  next_upper;
	logic [rsa_pkg::LIMIT_W-1:0]  next_lower;
	logic [rsa_pkg::HYST_W-1:0]   next_hyst;
	logic [rsa_pkg::NUM_TRIP-1:0] next_mask;
	logic [rsa_pkg::SPAN_W-1:0]   next_span;
	logic                         next_ref_off;
	logic                         next_sup_low;
	logic                         next_sup_high;
	logic [rsa_pkg::DATA_W-1:0]   next_rdata;
	logic                         next_irq;
	logic                         input_low_active;
	logic                         input_high_active;
	logic [RESULT_W-1:0]          hyst_res;
	logic [rsa_pkg::NUM_TRIP-1:0] trip_set;
	logic [rsa_pkg::NUM_TRIP-1:0] trip_clr;
	logic [rsa_pkg::NUM_TRIP-1:0] trip;
	logic [rsa_pkg::NUM_TRIP-1:0] irq_clr;
	logic [rsa_pkg::NUM_TRIP-1:0] irq_stat;
	logic                         wr_range;
	logic                         wr_upper;
	logic                         wr_lower;
	logic                         rd_status;

	assign wr_range = reg_wr_in && (reg_addr_in == rsa_pkg::RANGE_OFS);
	assign wr_upper = reg_wr_in && (reg_addr_in == rsa_pkg::UPPER_OFS);
	assign wr_lower = reg_wr_in && (reg_addr_in == rsa_pkg::LOWER_OFS);
	assign rd_status = reg_rd_in && (reg_addr_in == rsa_pkg::STATUS_OFS);
	// the status offset has no write decode, so host writes never touch a flag

	// control registers
	always_comb begin
		next_span = span_code_out;
		next_ref_off = onchip_reference_off_out;
		next_upper = input_upper_limit;
		next_lower = input_lower_limit;
		next_hyst = input_limit_hysteresis;
		next_mask = irq_mask;
		if (wr_range) begin
			next_ref_off = reg_wdata_in[rsa_pkg::REF_OFF_BIT];
			// an undefined code would leave the front end in an unknown span, so drop it
			if (rsa_pkg::span_code_defined(reg_wdata_in[rsa_pkg::SPAN_W-1:0])) begin
				next_span = reg_wdata_in[rsa_pkg::SPAN_W-1:0];
			end
		end
		if (wr_upper) begin
			next_upper = reg_wdata_in[rsa_pkg::LIMIT_W-1:0];
			// low two hysteresis bits must stay zero; they are forced so here
			next_hyst = {reg_wdata_in[rsa_pkg::DATA_W-1:rsa_pkg::HYST_LSB+2], 2'h0};
		end
		if (wr_lower) begin
			next_lower = reg_wdata_in[rsa_pkg::LIMIT_W-1:0];
		end
		if (reg_wr_in && (reg_addr_in == rsa_pkg::IRQ_MASK_OFS)) begin
			next_mask = reg_wdata_in[rsa_pkg::NUM_TRIP-1:0];
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			span_code_out <= rsa_pkg::SPAN_RST;
			onchip_reference_off_out <= rsa_pkg::REF_OFF_RST;
			input_upper_limit <= rsa_pkg::UPPER_RST;
			input_lower_limit <= rsa_pkg::LOWER_RST;
			input_limit_hysteresis <= rsa_pkg::HYST_RST;
			irq_mask <= rsa_pkg::MASK_RST;
		end else begin
			span_code_out <= next_span;
			onchip_reference_off_out <= next_ref_off;
			input_upper_limit <= next_upper;
			input_lower_limit <= next_lower;
			input_limit_hysteresis <= next_hyst;
			irq_mask <= next_mask;
		end
	end

	// live alarms: supply flags track the monitors, input flags update per conversion
	always_comb begin
		next_sup_low = analog_supply_low_in;
		next_sup_high = analog_supply_high_in;
		hyst_res = {{(RESULT_W-rsa_pkg::HYST_W-2){1'b0}}, input_limit_hysteresis, 2'h0};
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			supply_low_active <= 1'b0;
			supply_high_active <= 1'b0;
		end else begin
			supply_low_active <= next_sup_low;
			supply_high_active <= next_sup_high;
		end
	end

	rsa_limit_cmp #(
		.RESULT_W (RESULT_W),
		.UPPER    (1'b1)
	) u_upper_cmp (
		.clk_in          (clk_in),
		.arst_n_in       (arst_n_in),
		.sample_valid_in (sample_valid_in),
		.sample_in       (sample_in),
		.limit_in        (rsa_pkg::limit_to_result(input_upper_limit)),
		.hyst_in         (hyst_res),
		.active_out      (input_high_active)
	);

	rsa_limit_cmp #(
		.RESULT_W (RESULT_W),
		.UPPER    (1'b0)
	) u_lower_cmp (
		.clk_in          (clk_in),
		.arst_n_in       (arst_n_in),
		.sample_valid_in (sample_valid_in),
		.sample_in       (sample_in),
		.limit_in        (rsa_pkg::limit_to_result(input_lower_limit)),
		.hyst_in         (hyst_res),
		.active_out      (input_low_active)
	);

	// latched alarms: a live alarm keeps setting, so a read during an alarm cannot lose it
	always_comb begin
		trip_set = '0;
		trip_set[rsa_pkg::TRIP_SUP_LOW] = supply_low_active;
		trip_set[rsa_pkg::TRIP_SUP_HIGH] = supply_high_active;
		trip_set[rsa_pkg::TRIP_IN_LOW] = input_low_active;
		trip_set[rsa_pkg::TRIP_IN_HIGH] = input_high_active;
		trip_clr = {rsa_pkg::NUM_TRIP{rd_status}};
		irq_clr = '0;
		if (reg_wr_in && (reg_addr_in == rsa_pkg::IRQ_STAT_OFS)) begin
			irq_clr = reg_wdata_in[rsa_pkg::NUM_TRIP-1:0];
		end
	end

	rsa_sticky #(
		.WIDTH (rsa_pkg::NUM_TRIP)
	) u_trip (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.set_in    (trip_set),
		.clr_in    (trip_clr),
		.flag_out  (trip)
	);

	// interrupt status records each new trip; write one to clear
	rsa_sticky #(
		.WIDTH (rsa_pkg::NUM_TRIP)
	) u_irq_stat (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.set_in    (trip_set & ~trip),
		.clr_in    (irq_clr),
		.flag_out  (irq_stat)
	);

	// read data, one cycle after the strobe; status writes fall through untouched
	always_comb begin
		next_rdata = '0;
		next_irq = |(irq_stat & irq_mask);
		if (reg_rd_in) begin
			case (reg_addr_in)
				rsa_pkg::RANGE_OFS: begin
					next_rdata[rsa_pkg::REF_OFF_BIT] = onchip_reference_off_out;
					next_rdata[rsa_pkg::SPAN_W-1:0] = span_code_out;
				end
				rsa_pkg::STATUS_OFS: begin
					next_rdata[rsa_pkg::SUP_LOW_ACT_BIT] = supply_low_active;
					next_rdata[rsa_pkg::SUP_HIGH_ACT_BIT] = supply_high_active;
					next_rdata[rsa_pkg::IN_LOW_ACT_BIT] = input_low_active;
					next_rdata[rsa_pkg::IN_HIGH_ACT_BIT] = input_high_active;
					next_rdata[rsa_pkg::TRIP_LSB+:rsa_pkg::NUM_TRIP] = trip;
					next_rdata[rsa_pkg::SUMMARY_BIT] = |trip;
				end
				rsa_pkg::UPPER_OFS: begin
					next_rdata[rsa_pkg::HYST_LSB+:rsa_pkg::HYST_W] = input_limit_hysteresis;
					next_rdata[rsa_pkg::LIMIT_W-1:0] = input_upper_limit;
				end
				rsa_pkg::LOWER_OFS: begin
					next_rdata[rsa_pkg::LIMIT_W-1:0] = input_lower_limit;
				end
				rsa_pkg::IRQ_STAT_OFS: begin
					next_rdata[rsa_pkg::NUM_TRIP-1:0] = irq_stat;
				end
				rsa_pkg::IRQ_MASK_OFS: begin
					next_rdata[rsa_pkg::NUM_TRIP-1:0] = irq_mask;
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rdata_out <= '0;
			irq_out <= 1'b0;
		end else begin
			reg_rdata_out <= next_rdata;
			irq_out <= next_irq;
		end
	end

	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_range_rd;
		reg_rd_in && (reg_addr_in == rsa_pkg::RANGE_OFS);
	endsequence

	sequence s_status_rd;
		reg_rd_in && (reg_addr_in == rsa_pkg::STATUS_OFS);
	endsequence

	a_range_rsvd_zero: assert property (s_range_rd |=> (reg_rdata_out[31:7] == 25'h0000000)
		&& (reg_rdata_out[5:4] == 2'h0))
		else $error("range register reserved bits not zero");

	a_status_rsvd_zero: assert property (s_status_rd |=> (reg_rdata_out[31:16] == 16'h0000)
		&& (reg_rdata_out[13:12] == 2'h0) && (reg_rdata_out[9:8] == 2'h0)
		&& (reg_rdata_out[3:1] == 3'h0))
		else $error("status reserved bits not zero");

	a_ref_off_write: assert property (wr_range ##1 s_range_rd |=>
		reg_rdata_out[6] == $past(reg_wdata_in[6], 2))
		else $error("reference control did not take written value");

	a_span_bad_kept: assert property (wr_range
		&& !rsa_pkg::span_code_defined(reg_wdata_in[3:0]) |=> $stable(span_code_out))
		else $error("undefined span code was accepted");

	a_span_good_taken: assert property (wr_range
		&& rsa_pkg::span_code_defined(reg_wdata_in[3:0]) |=> span_code_out == $past(reg_wdata_in[3:0]))
		else $error("defined span code not taken");

	a_supply_low_live: assert property (analog_supply_low_in ##1 s_status_rd |=>
		reg_rdata_out[15])
		else $error("live low supply flag missing");

	a_supply_high_live: assert property (!analog_supply_high_in ##1 s_status_rd |=>
		!reg_rdata_out[14])
		else $error("live high supply flag stuck");

	a_summary_or: assert property (s_status_rd |=> reg_rdata_out[0] == |reg_rdata_out[7:4])
		else $error("summary bit differs from OR of latched flags");

	a_status_wr_ignored: assert property (reg_wr_in && (reg_addr_in == rsa_pkg::STATUS_OFS)
		&& (trip_set == 4'h0) && !rd_status |=> $stable(trip))
		else $error("status write changed a latched flag");

	a_read_clears_trip: assert property (rd_status && (trip_set == 4'h0) |=> trip == 4'h0)
		else $error("status read did not clear latched flags");

	a_upper_trips: assert property (sample_valid_in
		&& (sample_in > {input_upper_limit, 2'h0}) |=> input_high_active ##1 trip[0])
		else $error("upper input alarm did not trip");

	a_lower_trips: assert property (sample_valid_in
		&& (sample_in < {input_lower_limit, 2'h0}) |=> input_low_active ##1 trip[1])
		else $error("lower input alarm did not trip");

	a_hyst_low_zero: assert property (input_limit_hysteresis[1:0] == 2'h0)
		else $error("hysteresis low bits not zero");
endmodule

// *** rtl/rsa_sticky.sv ***
// sticky flag vector: set beats clear in the same cycle
`timescale 1ns/1ps
module rsa_sticky #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             arst_n_in,
	// set and clear per bit
	input  wire logic [WIDTH-1:0] set_in,
	input  wire logic [WIDTH-1:0] clr_in,
	// held flags
	output logic      [WIDTH-1:0] flag_out
);
	logic [WIDTH-1:0] next_flag;

	always_comb begin
		next_flag = set_in | (flag_out & ~clr_in);
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flag_out <= '0;
		end else begin
			flag_out <= next_flag;
		end
	end
endmodule

// *** verification/test_range_select_and_alarm_status.sv ***
// self-checking testbench of the range select and alarm status register bank
`timescale 1ns/1ps
module test_range_select_and_alarm_status;
	// clock and reset
	logic                               clk_in;
	logic                               arst_n_in;
	// register port
	logic [rsa_pkg::ADDR_W-1:0]         reg_addr_in;
	logic [rsa_pkg::DATA_W-1:0]         reg_wdata_in;
	logic                               reg_wr_in;
	logic                               reg_rd_in;
	logic [rsa_pkg::DATA_W-1:0]         reg_rdata_out;
	// monitors and controls
	logic                               sample_valid_in;
	logic [rsa_pkg::RESULT_W-1:0]       sample_in;
	logic                               analog_supply_low_in;
	logic                               analog_supply_high_in;
	logic [rsa_pkg::SPAN_W-1:0]         span_code_out;
	logic                               onchip_reference_off_out;
	logic                               irq_out;
	int                                 n_mismatch;
	int                                 num_checks;

	rsa_range_alarm dut_u (
		.clk_in                   (clk_in),
		.arst_n_in                (arst_n_in),
		.reg_addr_in              (reg_addr_in),
		.reg_wdata_in             (reg_wdata_in),
		.reg_wr_in                (reg_wr_in),
		.reg_rd_in                (reg_rd_in),
		.reg_rdata_out            (reg_rdata_out),
		.sample_valid_in          (sample_valid_in),
		.sample_in                (sample_in),
		.analog_supply_low_in     (analog_supply_low_in),
		.analog_supply_high_in    (analog_supply_high_in),
		.span_code_out            (span_code_out),
		.onchip_reference_off_out (onchip_reference_off_out),
		.irq_out                  (irq_out)
	);

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
		@(posedge clk_in);
		reg_addr_in <= addr;
		reg_wdata_in <= data;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so look there
	task automatic reg_read_check(input logic [7:0] addr, input logic [31:0] exp);
		@(posedge clk_in);
		reg_addr_in <= addr;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		check_word(reg_rdata_out, exp);
	endtask

	task automatic send_sample(input logic [17:0] v);
		@(posedge clk_in);
		sample_valid_in <= 1'b1;
		sample_in <= v;
		@(posedge clk_in);
		sample_valid_in <= 1'b0;
	endtask

	task automatic supplies(input logic low, input logic high);
		@(posedge clk_in);
		analog_supply_low_in <= low;
		analog_supply_high_in <= high;
		idle(3);
	endtask

	task automatic test_reset_values;
		reg_read_check(rsa_pkg::RANGE_OFS, 32'h0);
		reg_read_check(rsa_pkg::STATUS_OFS, 32'h0);
		reg_read_check(rsa_pkg::UPPER_OFS, 32'h0000FFFF);
		reg_read_check(rsa_pkg::LOWER_OFS, 32'h0);
		reg_read_check(rsa_pkg::IRQ_MASK_OFS, 32'h0);
		reg_read_check(8'h3C, 32'h0);
		@(posedge clk_in);
		#1;
		check_word(reg_rdata_out, 32'h0);
		check_bit(onchip_reference_off_out, 1'b0);
		check_word({28'h0, span_code_out}, 32'h0);
		check_bit(irq_out, 1'b0);
	endtask

	// every code with all reserved bits set; undefined codes keep the old span
	task automatic test_range_codes;
		logic [3:0] exp_span;
		logic [3:0] c;
		exp_span = 4'h0;
		for (int i = 0; i < 16; i++) begin
			c = 4'(i);
			if (c <= 4'h4 || (c >= 4'h8 && c <= 4'hB)) begin
				exp_span = c;
			end
			reg_write(rsa_pkg::RANGE_OFS, {25'h1FFFFFF, c[0], 2'h3, c});
			reg_read_check(rsa_pkg::RANGE_OFS, {25'h0, c[0], 2'h0, exp_span});
			check_word({28'h0, span_code_out}, {28'h0, exp_span});
			check_bit(onchip_reference_off_out, c[0]);
		end
	endtask

	task automatic test_supply(input logic high);
		logic [31:0] live;
		logic [31:0] trip;
		live = high ? 32'h00004000 : 32'h00008000;
		trip = high ? 32'h00000041 : 32'h00000081;
		supplies(!high, high);
		reg_read_check(rsa_pkg::STATUS_OFS, live | trip);
		reg_read_check(rsa_pkg::STATUS_OFS, live | trip);
		supplies(1'b0, 1'b0);
		reg_write(rsa_pkg::STATUS_OFS, 32'hFFFFFFFF);
		reg_read_check(rsa_pkg::STATUS_OFS, trip);
		reg_read_check(rsa_pkg::STATUS_OFS, 32'h0);
	endtask

	// upper limit 0x4000 and lower 0x2000 in result units, hysteresis 0x10
	task automatic test_input_alarms;
		logic [17:0] smp [12] = '{18'h3000, 18'h4000, 18'h4001, 18'h3FF0, 18'h3FEF,
			18'h3000, 18'h2000, 18'h1FFF, 18'h2010, 18'h2011, 18'h3000, 18'h3000};
		logic [31:0] exp [12] = '{32'h0, 32'h0, 32'h0411, 32'h0411, 32'h0011,
			32'h0, 32'h0, 32'h0821, 32'h0821, 32'h0021, 32'h0, 32'h0};
		reg_write(rsa_pkg::UPPER_OFS, 32'h07FF1000);
		reg_read_check(rsa_pkg::UPPER_OFS, 32'h04001000);
		reg_write(rsa_pkg::LOWER_OFS, 32'hFFFF0800);
		reg_read_check(rsa_pkg::LOWER_OFS, 32'h00000800);
		for (int i = 0; i < 12; i++) begin
			send_sample(smp[i]);
			idle(2);
			reg_read_check(rsa_pkg::STATUS_OFS, exp[i]);
		end
	endtask

	task automatic test_interrupt;
		reg_write(rsa_pkg::IRQ_STAT_OFS, 32'hF);
		reg_read_check(rsa_pkg::IRQ_STAT_OFS, 32'h0);
		reg_write(rsa_pkg::IRQ_MASK_OFS, 32'h8);
		supplies(1'b1, 1'b1);
		#1;
		check_bit(irq_out, 1'b1);
		reg_read_check(rsa_pkg::IRQ_STAT_OFS, 32'hC);
		reg_write(rsa_pkg::IRQ_MASK_OFS, 32'h0);
		idle(2);
		check_bit(irq_out, 1'b0);
		reg_write(rsa_pkg::IRQ_MASK_OFS, 32'h8);
		idle(2);
		check_bit(irq_out, 1'b1);
		// clearing while the cause lasts must stick: only a new trip sets it again
		reg_write(rsa_pkg::IRQ_STAT_OFS, 32'h8);
		idle(2);
		check_bit(irq_out, 1'b0);
		reg_read_check(rsa_pkg::IRQ_STAT_OFS, 32'h4);
		supplies(1'b0, 1'b0);
		reg_read_check(rsa_pkg::STATUS_OFS, 32'h00C1);
		reg_read_check(rsa_pkg::STATUS_OFS, 32'h0);
	endtask

	// write then read with no gap between the strobes, as the bus allows
	task automatic test_back_to_back;
		@(posedge clk_in);
		reg_addr_in <= rsa_pkg::RANGE_OFS;
		reg_wdata_in <= 32'hFFFFFF82;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		check_word(reg_rdata_out, 32'h00000002);
		check_bit(onchip_reference_off_out, 1'b0);
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		n_mismatch = 0;
		num_checks = 0;
		arst_n_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 32'h0;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		sample_valid_in = 1'b0;
		sample_in = 18'h0;
		analog_supply_low_in = 1'b0;
		analog_supply_high_in = 1'b0;
		repeat (12) @(posedge clk_in);
		arst_n_in <= 1'b1;
		test_reset_values();
		test_range_codes();
		test_back_to_back();
		test_supply(1'b0);
		test_supply(1'b1);
		test_input_alarms();
		test_interrupt();
		print_verdict();
	end

	// the whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk_in);
		n_mismatch++;
		$display("watchdog expired at %0t ns", $time);
		print_verdict();
	end
endmodule
